// >>> xpc_pkg.sv
// Constants for the crosspoint configuration port controller
// How it works
// - Broadcast address with enable and input 7 programs every row.
// - Address 16 with enable and input 32 programs row 16 only.
// - Update strobe low with select copies first rank into second rank.
// - Each pin vector is held stable for one vector period.
// - Fast mode drops the idle vectors after disable, writes and update.
// - Write strobe is held low for at least the minimum width.
// - Update strobe is held low for at least the minimum width.
// - Disable line is held low for at least the minimum width.
package xpc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int VECTOR_PERIOD_NS = 15;
  localparam int STROBE_MIN_NS = 15;
  localparam int DISABLE_PULSE_MIN_NS = 15;
  localparam int VECTOR_PERIOD_CYC =
    (VECTOR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_MIN_CYC =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISABLE_PULSE_MIN_CYC =
    (DISABLE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_SETTLE_CYC = 4;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 7;
  localparam int ENABLE_POS = 6;
  localparam int INPUT_LSB = 0;
  localparam int INPUT_W = 6;
  localparam logic [ADDR_W-1:0] BROADCAST_ADDR = 5'h11;
  localparam logic [ADDR_W-1:0] LAST_OUTPUT_ADDR = 5'h10;
  localparam logic [2:0] OP_DISABLE = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_UPDATE = 3'h2;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [2:0] OP_END = 3'h4;
  typedef enum logic [3:0] {
    XPC_IDLE = 4'b0000,
    XPC_DIS_LOW = 4'b0001,
    XPC_DIS_IDLE = 4'b0010,
    XPC_WR_SETUP = 4'b0011,
    XPC_WR_STROBE = 4'b0100,
    XPC_WR_IDLE = 4'b0101,
    XPC_UPD_STROBE = 4'b0110,
    XPC_UPD_IDLE = 4'b0111,
    XPC_RD_SETUP = 4'b1000,
    XPC_RD_WAIT = 4'b1001,
    XPC_DESELECT = 4'b1010
  } xpc_state_t;
endpackage

// >>> xpc_sync.sv
// Three-stage synchroniser for the readback data bus
`timescale 1ns/10ps
module xpc_sync
  import xpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [DATA_W-1:0] async_in,
  output logic [DATA_W-1:0] sync_out,
  output logic stable
);
  logic [DATA_W-1:0] s1_reg;
  logic [DATA_W-1:0] s2_reg;
  logic [DATA_W-1:0] s3_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 7'h00;
      s2_reg <= 7'h00;
      s3_reg <= 7'h00;
    end else if (ce) begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign sync_out = s3_reg;
  assign stable = (s2_reg == s3_reg);
endmodule

// >>> xpc_ctrl.sv
// Controller that programs the crosspoint through its parallel pins
`timescale 1ns/10ps
module xpc_ctrl
  import xpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic fast_mode,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_data,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic global_disable_n,
  output logic select_n,
  output logic write_n,
  output logic second_rank_read_n,
  output logic update_n,
  output logic [ADDR_W-1:0] out_addr,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_i
);
  xpc_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [DATA_W-1:0] rd_sync;
  logic rd_stable;

  ////////////////////////////////////////////////////////////////////////
  // Readback path
  xpc_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .async_in(data_i),
    .sync_out(rd_sync),
    .stable(rd_stable)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= XPC_IDLE;
      cnt_reg <= 4'h0;
    end else if (ce) begin
      case (state_reg)
        XPC_IDLE: begin
          cnt_reg <= 4'h0;
          if (cmd_valid && cmd_ready) begin
            case (cmd_op)
              OP_DISABLE: state_reg <= XPC_DIS_LOW;
              OP_WRITE: state_reg <= XPC_WR_SETUP;
              OP_UPDATE: state_reg <= XPC_UPD_STROBE;
              OP_READ: state_reg <= XPC_RD_SETUP;
              OP_END: state_reg <= XPC_DESELECT;
              default: state_reg <= XPC_IDLE;
            endcase
          end
        end
        XPC_DIS_LOW: begin
          if (cnt_reg >= 4'(DISABLE_PULSE_MIN_CYC - 1)) begin
            cnt_reg <= 4'h0;
            state_reg <= fast_mode ? XPC_IDLE : XPC_DIS_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        XPC_WR_SETUP: begin
          if (cnt_reg >= 4'(VECTOR_PERIOD_CYC - 1)) begin
            cnt_reg <= 4'h0;
            state_reg <= XPC_WR_STROBE;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        XPC_WR_STROBE: begin
          if (cnt_reg >= 4'(STROBE_MIN_CYC - 1)) begin
            cnt_reg <= 4'h0;
            state_reg <= fast_mode ? XPC_IDLE : XPC_WR_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        XPC_UPD_STROBE: begin
          if (cnt_reg >= 4'(STROBE_MIN_CYC - 1)) begin
            cnt_reg <= 4'h0;
            state_reg <= fast_mode ? XPC_IDLE : XPC_UPD_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        XPC_RD_SETUP: begin
          cnt_reg <= 4'h0;
          state_reg <= XPC_RD_WAIT;
        end
        XPC_RD_WAIT: begin
          if (cnt_reg >= 4'(READ_SETTLE_CYC - 1) && rd_stable) begin
            cnt_reg <= 4'h0;
            state_reg <= XPC_IDLE;
          end else if (cnt_reg < 4'(READ_SETTLE_CYC - 1)) begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        XPC_DIS_IDLE, XPC_WR_IDLE, XPC_UPD_IDLE, XPC_DESELECT: begin
          cnt_reg <= 4'h0;
          state_reg <= XPC_IDLE;
        end
        default: begin
          cnt_reg <= 4'h0;
          state_reg <= XPC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command handshake and readback answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 7'h00;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      if (state_reg == XPC_IDLE) begin
        cmd_ready <= !(cmd_valid && cmd_ready);
      end else begin
        cmd_ready <= 1'b0;
      end
      if (state_reg == XPC_RD_WAIT && rd_stable &&
          cnt_reg >= 4'(READ_SETTLE_CYC - 1)) begin
        rsp_valid <= 1'b1;
        rsp_data <= rd_sync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      global_disable_n <= 1'b1;
      select_n <= 1'b1;
      write_n <= 1'b1;
      second_rank_read_n <= 1'b1;
      update_n <= 1'b1;
      out_addr <= 5'h00;
      data_o <= 7'h00;
      data_oe <= 1'b0;
    end else if (ce) begin
      global_disable_n <= 1'b1;
      write_n <= 1'b1;
      update_n <= 1'b1;
      second_rank_read_n <= 1'b1;
      if (state_reg == XPC_IDLE && cmd_valid && cmd_ready) begin
        case (cmd_op)
          OP_DISABLE: begin
            global_disable_n <= 1'b0;
            select_n <= 1'b1;
            data_oe <= 1'b0;
          end
          OP_WRITE: begin
            select_n <= 1'b0;
            out_addr <= cmd_addr;
            data_o <= cmd_data;
            data_oe <= 1'b1;
          end
          OP_UPDATE: begin
            select_n <= 1'b0;
            update_n <= 1'b0;
            data_oe <= 1'b0;
          end
          OP_READ: begin
            select_n <= 1'b0;
            out_addr <= cmd_addr;
            data_oe <= 1'b0;
          end
          OP_END: begin
            select_n <= 1'b1;
            data_oe <= 1'b0;
          end
          default: begin
            data_oe <= data_oe;
          end
        endcase
      end else begin
        case (state_reg)
          XPC_DIS_LOW: begin
            if (cnt_reg < 4'(DISABLE_PULSE_MIN_CYC - 1)) begin
              global_disable_n <= 1'b0;
            end
          end
          XPC_WR_SETUP: begin
            if (cnt_reg >= 4'(VECTOR_PERIOD_CYC - 1)) begin
              write_n <= 1'b0;
            end
          end
          XPC_WR_STROBE: begin
            if (cnt_reg < 4'(STROBE_MIN_CYC - 1)) begin
              write_n <= 1'b0;
            end
          end
          XPC_UPD_STROBE: begin
            if (cnt_reg < 4'(STROBE_MIN_CYC - 1)) begin
              update_n <= 1'b0;
            end
          end
          XPC_RD_SETUP: begin
            second_rank_read_n <= 1'b0;
          end
          XPC_RD_WAIT: begin
            if (!(cnt_reg >= 4'(READ_SETTLE_CYC - 1) && rd_stable)) begin
              second_rank_read_n <= 1'b0;
            end
          end
          default: begin
            write_n <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// >>> xpc_monitor.sv
// Checker for the crosspoint port controller pins
`timescale 1ns/10ps
module xpc_monitor
  import xpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic global_disable_n,
  input wire logic select_n,
  input wire logic write_n,
  input wire logic second_rank_read_n,
  input wire logic update_n,
  input wire logic [ADDR_W-1:0] out_addr,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe
);
  logic take;
  assign take = ce && cmd_valid && cmd_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_WR_CYCLE: assert property (
    !write_n |-> !select_n && data_oe && update_n && global_disable_n)
    else $error("write strobe outside a write vector");
  AST_WR_TAKE: assert property (
    take && cmd_op == OP_WRITE |-> ##2 !write_n ##1 write_n)
    else $error("write strobe not one cycle after setup");
  AST_WR_SETUP: assert property (
    $fell(write_n) |-> $stable(out_addr) && $stable(data_o)
      && !$past(select_n))
    else $error("write vector not set up before strobe");
  AST_WR_HOLD: assert property (
    $rose(write_n) |-> $stable(out_addr) && $stable(data_o) && !select_n)
    else $error("write vector changed with strobe");
  AST_UPD_CYCLE: assert property (
    !update_n |-> !select_n && write_n && second_rank_read_n && !data_oe)
    else $error("update strobe outside update vector");
  AST_UPD_WIDTH: assert property (
    take && cmd_op == OP_UPDATE |=> !update_n ##1 update_n)
    else $error("update pulse wrong");
  AST_DIS_WIDTH: assert property (
    take && cmd_op == OP_DISABLE |=> !global_disable_n ##1 global_disable_n)
    else $error("disable pulse wrong");
  AST_DIS_DESEL: assert property (
    !global_disable_n |-> select_n && write_n && update_n)
    else $error("disable pulse while selected");
  AST_RD_BUS: assert property (
    !second_rank_read_n |-> !select_n && !data_oe && write_n)
    else $error("bus driven during readback");
  AST_END: assert property (
    take && cmd_op == OP_END |-> ##[1:3] select_n)
    else $error("session not ended");
endmodule
bind xpc_ctrl xpc_monitor u_xpc_monitor (.clk, .nrst, .ce, .cmd_valid,
  .cmd_ready, .cmd_op, .global_disable_n, .select_n, .write_n,
  .second_rank_read_n, .update_n, .out_addr, .data_o, .data_oe);

// >>> xpc_dev_model.sv
// Behavioural crosspoint device at the far side of the pins
`timescale 1ns/10ps
module xpc_dev_model
  import xpc_pkg::*;
(
  input wire logic global_disable_n,
  input wire logic select_n,
  input wire logic write_n,
  input wire logic second_rank_read_n,
  input wire logic update_n,
  input wire logic [ADDR_W-1:0] out_addr,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe,
  output logic [DATA_W-1:0] data_i
);
  logic [16:0][DATA_W-1:0] r1;
  logic [16:0][DATA_W-1:0] r2;
  always @(global_disable_n, select_n, write_n, update_n, out_addr,
    data_o) begin
    if (!select_n && !write_n) begin
      for (int i = 0; i < 17; i++) begin
        if (out_addr == BROADCAST_ADDR || out_addr == i) begin
          r1[i] = data_o;
        end
      end
    end
    if (!select_n && !update_n) begin
      r2 = r1;
    end
    if (!global_disable_n) begin
      for (int i = 0; i < 17; i++) begin
        r2[i][ENABLE_POS] = 1'b0;
      end
    end
  end
  // Undriven bus shows the inverse of the last controller value
  assign data_i = (!select_n && !second_rank_read_n) ? r2[out_addr]
    : data_oe ? data_o : ~data_o;
endmodule

// >>> tb_top.sv
// Testbench for the crosspoint port controller
`timescale 1ns/10ps
module tb_top
  import xpc_pkg::*;
();
  logic clk, nrst, ce, fast_mode, cmd_valid, cmd_ready, rsp_valid, data_oe;
  logic global_disable_n, select_n, write_n, second_rank_read_n, update_n;
  logic [2:0] cmd_op;
  logic [ADDR_W-1:0] cmd_addr, out_addr;
  logic [DATA_W-1:0] cmd_data, rsp_data, data_o, data_i;
  int mismatches = 0;
  int tests_run = 0;
  int cmd_cycles = 0;
  xpc_ctrl u_xpc_ctrl (.clk, .nrst, .ce, .fast_mode, .cmd_valid,
    .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .rsp_valid, .rsp_data,
    .global_disable_n, .select_n, .write_n, .second_rank_read_n,
    .update_n, .out_addr, .data_o, .data_oe, .data_i);
  xpc_dev_model u_xpc_dev_model (.global_disable_n, .select_n, .write_n,
    .second_rank_read_n, .update_n, .out_addr, .data_o, .data_oe, .data_i);
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d wrong %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd);
    int n;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      cmd_valid <= 1'b0;
      if (rsp_valid === 1'b1) rd = rsp_data;
      n++;
    end while ((n < 2 || cmd_ready !== 1'b1) && n < 60);
    cmd_cycles = n;
    chk("cmd_ready", 7'h01, {6'h00, cmd_ready});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_session(input logic f, input logic [DATA_W-1:0] b);
    logic [DATA_W-1:0] rd;
    fast_mode <= f;
    cmd(OP_DISABLE, 5'h00, 7'h00, rd);
    cmd(OP_WRITE, BROADCAST_ADDR, b, rd);
    cmd(OP_WRITE, LAST_OUTPUT_ADDR, 7'h60, rd);
    chk("wr_cycles", f ? 7'h05 : 7'h06, 7'(cmd_cycles));
    cmd(OP_UPDATE, 5'h00, 7'h00, rd);
    for (int i = 0; i < 16; i++) begin
      chk("row", b, u_xpc_dev_model.r2[i]);
    end
    chk("row16", 7'h60, u_xpc_dev_model.r2[16]);
    cmd(OP_READ, LAST_OUTPUT_ADDR, 7'h00, rd);
    chk("read16", 7'h60, rd);
    cmd(OP_READ, 5'h03, 7'h00, rd);
    chk("read3", b, rd);
    cmd(OP_END, 5'h00, 7'h00, rd);
    chk("deselect", 7'h01, {6'h00, select_n});
    $display("session test done fast %0d", f);
  endtask
  task automatic t_freeze;
    logic [DATA_W-1:0] rd;
    ce <= 1'b0;
    cmd(OP_DISABLE, 5'h00, 7'h00, rd);
    repeat (3) @(posedge clk);
    chk("frozen", 7'h60, u_xpc_dev_model.r2[16]);
    ce <= 1'b1;
    @(posedge clk);
    $display("freeze test done");
  endtask
  task automatic t_disable;
    logic [DATA_W-1:0] rd;
    cmd(OP_DISABLE, 5'h00, 7'h00, rd);
    for (int i = 0; i < 17; i++) begin
      chk("en", 7'h00, {6'h00, u_xpc_dev_model.r2[i][ENABLE_POS]});
    end
    chk("rank1", 7'h60, u_xpc_dev_model.r1[16]);
    cmd(OP_READ, LAST_OUTPUT_ADDR, 7'h00, rd);
    chk("readoff", 7'h20, rd);
    cmd(OP_END, 5'h00, 7'h00, rd);
    $display("disable test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  initial begin
    #(CLK_PERIOD_NS * 3000);
    mismatches++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    fast_mode = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_addr = 5'h00;
    cmd_data = 7'h00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_session(1'b0, 7'h47);
    t_freeze();
    t_disable();
    t_session(1'b1, 7'h05);
    test_done();
  end
endmodule
